// ==== design/scse_alu.sv ====
// Overview of operation
// RULE1: Context save takes a task-number RAM address and a 20-bit table base.
// RULE2: Selection byte sits at table base plus twice the task number, correction next.
// RULE3: Each selection bit marks one register; one means saved, zero means skipped.
// RULE4: Selected registers are saved one after another, frame base register first.
// RULE5: Stack pointer drops by the table correction, which software sets to bytes saved.
// RULE6: Extended store writes byte or word source to a 20-bit destination address.
// RULE7: Byte store from address register keeps low 8 bits, flags from full 16.
// RULE8: Sign flag follows result top bit; zero flag set on zero result.
// RULE9: Store-if-nonzero writes the immediate only while the zero flag is clear.
// RULE10: Store-if-zero writes the immediate only while the zero flag is set.
// RULE11: Select-store writes first immediate if zero flag set, else the second.
// RULE12: Subtract writes destination minus source back into the destination.
// RULE13: Byte subtract into address register zero-extends source; from it uses low byte.
// RULE14: Software never names address registers as both byte subtract operands.
// RULE15: Overflow set when signed difference leaves the byte or word range.
// RULE16: Carry set when no borrow occurs, cleared on borrow.
// RULE17: Conditional stores change no flags; they only read the zero flag.
package scse_pkg;
  typedef enum logic [2:0] {
    SCSE_OP_CTX = 3'h0,
    SCSE_OP_EXT = 3'h1,
    SCSE_OP_STORE_IF_NONZERO_OP = 3'h2,
    SCSE_OP_STZ = 3'h3,
    SCSE_OP_SELECT_STORE_ON_ZERO_OP = 3'h4,
    SCSE_OP_SUB = 3'h5
  } scse_op_type;

  // Gray codes along the context-save path, except the SCSE_WR_TWO to SCSE_SCAN loop back, which changes two bits.
  typedef enum logic [2:0] {
    SCSE_IDLE = 3'h0,
    SCSE_RD_TASK = 3'h1,
    SCSE_RD_SEL = 3'h3,
    SCSE_RD_CORR = 3'h2,
    SCSE_SCAN = 3'h6,
    SCSE_WR_ONE = 3'h7,
    SCSE_WR_TWO = 3'h5,
    SCSE_FINISH = 3'h4
  } scse_state_type;

  localparam logic [2:0] SCSE_FIRST_REG = 3'h0;
  localparam logic [2:0] SCSE_LAST_REG = 3'h7;
  localparam logic [15:0] SCSE_REG_BYTES = 16'h0002;

  // Returns {sign, zero} for a byte or word value.
  function automatic logic [1:0] scse_sz(input logic [15:0] v, input logic wide);
    logic [1:0] r;
    r = wide ? {v[15], v == 16'h0000} : {v[7], v[7:0] == 8'h00};
    return r;
  endfunction : scse_sz
endpackage : scse_pkg

module scse_alu (
  // Operands
  input wire logic word_in,
  input wire logic src_areg_in,
  input wire logic dst_areg_in,
  input wire logic [15:0] src_in,
  input wire logic [15:0] dst_in,
  // Result and flags
  output logic [15:0] diff_out,
  output logic s_out,
  output logic z_out,
  output logic o_out,
  output logic c_out
);
  import scse_pkg::*;
  logic wide;
  logic [15:0] a;
  logic [15:0] b;
  logic [16:0] full;
  logic top_a;
  logic top_b;
  logic top_r;

  always_comb begin
    // An address-register destination widens a byte subtract to 16 bits.
    wide = word_in | dst_areg_in; // see RULE13
    a = wide ? dst_in : {8'h00, dst_in[7:0]};
    // A byte source is zero-extended even when the destination widens the subtract.
    b = word_in ? src_in : {8'h00, src_in[7:0]}; // see RULE13
    full = {1'b0, a} - {1'b0, b}; // see RULE12
    diff_out = wide ? full[15:0] : {8'h00, full[7:0]};
    {s_out, z_out} = scse_sz(diff_out, wide); // see RULE8
    top_a = wide ? a[15] : a[7];
    top_b = wide ? b[15] : b[7];
    top_r = wide ? diff_out[15] : diff_out[7];
    o_out = (top_a != top_b) && (top_r != top_a); // see RULE15
    c_out = wide ? !full[16] : (a[7:0] >= b[7:0]); // see RULE16
  end
endmodule : scse_alu

// ==== design/scse_core.sv ====
module scse_core (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Instruction request
  input wire logic start_in,
  input wire scse_pkg::scse_op_type op_in,
  input wire logic word_in,
  input wire logic src_areg_in,
  input wire logic dst_areg_in,
  input wire logic dst_mem_in,
  input wire logic [15:0] src_in,
  input wire logic [15:0] dst_in,
  input wire logic [7:0] imm_first_in,
  input wire logic [7:0] imm_second_in,
  input wire logic [19:0] dst_addr_in,
  input wire logic [15:0] task_addr_in,
  input wire logic [19:0] table_addr_in,
  input wire logic [15:0] sp_in,
  input wire logic flag_z_in,
  // Register file read for context save
  input wire logic [15:0] ctx_reg_val_in,
  output logic [2:0] ctx_reg_sel_out,
  // Data memory, one byte per access
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [19:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_ack_in,
  // Register and flag write back
  output logic reg_we_out,
  output logic [15:0] reg_wdata_out,
  output logic flag_we_out,
  output logic flag_s_out,
  output logic flag_z_out,
  output logic flag_o_out,
  output logic flag_c_out,
  output logic sp_we_out,
  output logic [15:0] sp_out,
  // Status
  output logic busy_out,
  output logic done_out
);
  import scse_pkg::*;

  scse_state_type state, next_state;
  scse_op_type op, next_op;
  logic word, next_word;
  logic [19:0] tbl, next_tbl;
  logic [15:0] sp_base, next_sp_base;
  logic [15:0] ptr, next_ptr;
  logic [7:0] sel, next_sel;
  logic [7:0] corr, next_corr;
  logic [15:0] data, next_data;
  logic [2:0] next_ctx_reg_sel;
  logic next_mem_req;
  logic next_mem_we;
  logic [19:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic next_reg_we;
  logic [15:0] next_reg_wdata;
  logic next_flag_we;
  logic next_flag_s;
  logic next_flag_z;
  logic next_flag_o;
  logic next_flag_c;
  logic next_sp_we;
  logic [15:0] next_sp_out;
  logic next_done;
  logic [15:0] diff;
  logic alu_s;
  logic alu_z;
  logic alu_o;
  logic alu_c;
  logic take;
  logic [7:0] pick;
  logic [15:0] store_val;
  logic [1:0] st_sz;

  scse_alu u_alu (
    .word_in(word_in),
    .src_areg_in(src_areg_in),
    .dst_areg_in(dst_areg_in),
    .src_in(src_in),
    .dst_in(dst_in),
    .diff_out(diff),
    .s_out(alu_s),
    .z_out(alu_z),
    .o_out(alu_o),
    .c_out(alu_c)
  );

  always_comb begin
    next_state = state;
    next_op = op;
    next_word = word;
    next_tbl = tbl;
    next_sp_base = sp_base;
    next_ptr = ptr;
    next_sel = sel;
    next_corr = corr;
    next_data = data;
    next_ctx_reg_sel = ctx_reg_sel_out;
    next_mem_addr = mem_addr_out;
    next_reg_we = 1'b0;
    next_reg_wdata = reg_wdata_out;
    next_flag_we = 1'b0;
    next_flag_s = flag_s_out;
    next_flag_z = flag_z_out;
    next_flag_o = flag_o_out;
    next_flag_c = flag_c_out;
    next_sp_we = 1'b0;
    next_sp_out = sp_out;
    next_done = 1'b0;
    take = ((op_in == SCSE_OP_STORE_IF_NONZERO_OP) && !flag_z_in) || // see RULE9
           ((op_in == SCSE_OP_STZ) && flag_z_in) || // see RULE10
           (op_in == SCSE_OP_SELECT_STORE_ON_ZERO_OP);
    pick = (op_in == SCSE_OP_SELECT_STORE_ON_ZERO_OP && !flag_z_in) ? imm_second_in : imm_first_in; // see RULE11
    // A byte store keeps the low byte, but flags look at the whole address register.
    store_val = word_in ? src_in : {8'h00, src_in[7:0]}; // see RULE7
    st_sz = scse_sz(src_in, word_in | src_areg_in); // see RULE7
    case (state)
      SCSE_IDLE: begin
        if (start_in) begin
          next_op = op_in;
          next_word = word_in;
          case (op_in)
            SCSE_OP_CTX: begin
              next_tbl = table_addr_in; // see RULE1
              next_sp_base = sp_in;
              next_ptr = sp_in;
              next_mem_addr = {4'h0, task_addr_in}; // see RULE1
              next_state = SCSE_RD_TASK;
            end
            SCSE_OP_EXT, SCSE_OP_SUB: begin
              next_data = (op_in == SCSE_OP_SUB) ? diff : store_val; // see RULE6
              next_word = word_in | (op_in == SCSE_OP_SUB && dst_areg_in);
              next_flag_we = 1'b1;
              if (op_in == SCSE_OP_SUB) begin
                {next_flag_s, next_flag_z} = {alu_s, alu_z}; // see RULE8
                next_flag_o = alu_o; // see RULE15
                next_flag_c = alu_c; // see RULE16
              end else begin
                {next_flag_s, next_flag_z} = st_sz; // see RULE8
              end
              if (dst_mem_in) begin
                next_mem_addr = dst_addr_in; // see RULE6
                next_state = SCSE_WR_ONE;
              end else begin
                next_reg_we = 1'b1; // see RULE12
                next_reg_wdata = next_data;
                next_state = SCSE_FINISH;
              end
            end
            default: begin
              // Conditional stores raise no flag write at all.
              next_word = 1'b0; // see RULE17
              next_data = {8'h00, pick};
              if (!take) begin
                next_state = SCSE_FINISH;
              end else if (dst_mem_in) begin
                next_mem_addr = dst_addr_in;
                next_state = SCSE_WR_ONE;
              end else begin
                next_reg_we = 1'b1;
                next_reg_wdata = {8'h00, pick};
                next_state = SCSE_FINISH;
              end
            end
          endcase
        end
      end
      SCSE_RD_TASK: begin
        if (mem_ack_in) begin
          next_mem_addr = tbl + {11'h000, mem_rdata_in, 1'b0}; // see RULE2
          next_state = SCSE_RD_SEL;
        end
      end
      SCSE_RD_SEL: begin
        if (mem_ack_in) begin
          next_sel = mem_rdata_in; // see RULE3
          next_mem_addr = mem_addr_out + 20'h00001; // see RULE2
          next_state = SCSE_RD_CORR;
        end
      end
      SCSE_RD_CORR: begin
        if (mem_ack_in) begin
          next_corr = mem_rdata_in;
          next_ctx_reg_sel = SCSE_FIRST_REG; // see RULE4
          next_state = SCSE_SCAN;
        end
      end
      SCSE_SCAN: begin
        // Bit 7 is the frame base register, walked downwards; a clear bit takes one cycle, a set bit also waits for its two byte writes.
        if (sel[3'h7 - ctx_reg_sel_out]) begin // see RULE3
          next_data = ctx_reg_val_in; // see RULE4
          next_ptr = ptr - SCSE_REG_BYTES;
          next_mem_addr = {4'h0, next_ptr} + 20'h00001;
          next_state = SCSE_WR_ONE;
        end else if (ctx_reg_sel_out == SCSE_LAST_REG) begin
          next_state = SCSE_FINISH;
        end else begin
          next_ctx_reg_sel = ctx_reg_sel_out + 3'h1; // see RULE4
        end
      end
      SCSE_WR_ONE: begin
        if (mem_ack_in) begin
          if (op == SCSE_OP_CTX) begin
            next_mem_addr = mem_addr_out - 20'h00001;
            next_state = SCSE_WR_TWO;
          end else if (word) begin
            next_mem_addr = mem_addr_out + 20'h00001;
            next_state = SCSE_WR_TWO;
          end else begin
            next_state = SCSE_FINISH;
          end
        end
      end
      SCSE_WR_TWO: begin
        if (mem_ack_in) begin
          if (op != SCSE_OP_CTX || ctx_reg_sel_out == SCSE_LAST_REG) begin
            next_state = SCSE_FINISH;
          end else begin
            next_ctx_reg_sel = ctx_reg_sel_out + 3'h1;
            next_state = SCSE_SCAN;
          end
        end
      end
      SCSE_FINISH: begin
        next_done = 1'b1;
        if (op == SCSE_OP_CTX) begin
          next_sp_we = 1'b1;
          next_sp_out = sp_base - {8'h00, corr}; // see RULE5
        end
        next_state = SCSE_IDLE;
      end
      default: begin
        next_state = SCSE_IDLE;
      end
    endcase
    next_mem_req = next_state inside {SCSE_RD_TASK, SCSE_RD_SEL, SCSE_RD_CORR,
                                      SCSE_WR_ONE, SCSE_WR_TWO};
    next_mem_we = next_state inside {SCSE_WR_ONE, SCSE_WR_TWO};
    // Context save writes the high byte first, stores write the low byte first.
    next_mem_wdata = ((next_state == SCSE_WR_ONE) == (next_op == SCSE_OP_CTX)) ?
                     next_data[15:8] : next_data[7:0];
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= SCSE_IDLE;
      op <= SCSE_OP_CTX;
      word <= 1'b0;
      tbl <= 20'h00000;
      sp_base <= 16'h0000;
      ptr <= 16'h0000;
      sel <= 8'h00;
      corr <= 8'h00;
      data <= 16'h0000;
      ctx_reg_sel_out <= 3'h0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= 20'h00000;
      mem_wdata_out <= 8'h00;
      reg_we_out <= 1'b0;
      reg_wdata_out <= 16'h0000;
      flag_we_out <= 1'b0;
      flag_s_out <= 1'b0;
      flag_z_out <= 1'b0;
      flag_o_out <= 1'b0;
      flag_c_out <= 1'b0;
      sp_we_out <= 1'b0;
      sp_out <= 16'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      word <= next_word;
      tbl <= next_tbl;
      sp_base <= next_sp_base;
      ptr <= next_ptr;
      sel <= next_sel;
      corr <= next_corr;
      data <= next_data;
      ctx_reg_sel_out <= next_ctx_reg_sel;
      mem_req_out <= next_mem_req;
      mem_we_out <= next_mem_we;
      mem_addr_out <= next_mem_addr;
      mem_wdata_out <= next_mem_wdata;
      reg_we_out <= next_reg_we;
      reg_wdata_out <= next_reg_wdata;
      flag_we_out <= next_flag_we;
      flag_s_out <= next_flag_s;
      flag_z_out <= next_flag_z;
      flag_o_out <= next_flag_o;
      flag_c_out <= next_flag_c;
      sp_we_out <= next_sp_we;
      sp_out <= next_sp_out;
      busy_out <= next_state != SCSE_IDLE;
      done_out <= next_done;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence seq_go(scse_op_type o);
    (state == SCSE_IDLE) && start_in && (op_in == o);
  endsequence

  sequence seq_cond_go;
    (state == SCSE_IDLE) && start_in &&
    (op_in inside {SCSE_OP_STORE_IF_NONZERO_OP, SCSE_OP_STZ, SCSE_OP_SELECT_STORE_ON_ZERO_OP});
  endsequence

  chk_cond_flags_kept: assert property (seq_cond_go |=> !flag_we_out [*2]) // see RULE17
    else $error("conditional store wrote flags");
  chk_nonzero_skip: assert property (seq_go(SCSE_OP_STORE_IF_NONZERO_OP) ##0 flag_z_in
    |=> !reg_we_out && !mem_req_out ##1 done_out) // see RULE9
    else $error("store-if-nonzero wrote while zero set");
  chk_zero_skip: assert property (seq_go(SCSE_OP_STZ) ##0 !flag_z_in
    |=> !reg_we_out && !mem_req_out ##1 done_out) // see RULE10
    else $error("store-if-zero wrote while zero clear");
  chk_select_value: assert property (seq_go(SCSE_OP_SELECT_STORE_ON_ZERO_OP) ##0 !dst_mem_in
    |=> reg_we_out && reg_wdata_out[7:0] ==
        ($past(flag_z_in) ? $past(imm_first_in) : $past(imm_second_in))) // see RULE11
    else $error("select-store wrote wrong immediate");
  chk_sub_word_result: assert property (seq_go(SCSE_OP_SUB) ##0 word_in && !dst_mem_in
    |=> reg_we_out && reg_wdata_out == $past(dst_in) - $past(src_in)
        && flag_c_out == ($past(dst_in) >= $past(src_in))) // see RULE12
    else $error("word subtract result or carry wrong");
  chk_sub_byte_ovf: assert property (seq_go(SCSE_OP_SUB) ##0 !word_in && !dst_areg_in
    && !src_areg_in |=> flag_o_out == ($signed($past(dst_in[7:0])) -
        $signed($past(src_in[7:0])) > 127 || $signed($past(dst_in[7:0])) -
        $signed($past(src_in[7:0])) < -128)) // see RULE15
    else $error("byte subtract overflow wrong");
  chk_store_areg_flags: assert property (seq_go(SCSE_OP_EXT) ##0 !word_in && src_areg_in
    |=> flag_we_out && flag_z_out == ($past(src_in) == 16'h0000)
        && flag_s_out == $past(src_in[15])) // see RULE7
    else $error("byte store flags not from full register");
  chk_table_addr: assert property ((state == SCSE_RD_TASK) && mem_ack_in
    |=> mem_req_out && mem_addr_out == tbl + {11'h000, $past(mem_rdata_in), 1'b0}) // see RULE2
    else $error("selection byte address wrong");
  chk_sp_correct: assert property ((state == SCSE_FINISH) && (op == SCSE_OP_CTX)
    |=> sp_we_out && sp_out == sp_base - {8'h00, corr} ##1 !sp_we_out) // see RULE5
    else $error("stack pointer correction wrong");
endmodule : scse_core

// ==== bench/scse_mem_model.sv ====
module scse_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Byte access from the core
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [19:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic ack_out,
  // Wait cycles before each acknowledge
  input wire logic [3:0] lat_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [19:0]];
  logic [27:0] wlog [$];
  logic [3:0] cnt;

  // Read data is only meaningful with the acknowledge, so it toggles otherwise
  // to expose a core that samples it late.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdata_out <= 8'h00;
    end else if (ack_out || !req_in) begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdata_out <= ~rdata_out;
    end else if (cnt == lat_in) begin
      ack_out <= 1'b1;
      if (we_in) begin
        mem[addr_in] = wdata_in;
        wlog.push_back({addr_in, wdata_in});
      end else begin
        rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 8'h00;
      end
    end else begin
      cnt <= cnt + 4'h1;
      rdata_out <= ~rdata_out;
    end
  end
endmodule : scse_mem_model

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scse_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic start_in = 1'b0;
  logic word_in = 1'b0;
  logic src_areg_in = 1'b0;
  logic dst_areg_in = 1'b0;
  logic dst_mem_in = 1'b0;
  logic flag_z_in = 1'b0;
  scse_op_type op_in = SCSE_OP_SUB;
  logic [15:0] src_in = 16'h0000;
  logic [15:0] dst_in = 16'h0000;
  logic [15:0] task_addr_in = 16'h0000;
  logic [15:0] sp_in = 16'h0000;
  logic [7:0] imm_first_in = 8'h3c;
  logic [7:0] imm_second_in = 8'hc3;
  logic [19:0] dst_addr_in = 20'h00000;
  logic [19:0] table_addr_in = 20'h00000;
  logic [3:0] lat = 4'h0;
  logic [15:0] ctx_reg_val_in;
  logic [7:0] mem_rdata_in;
  logic mem_ack_in;
  logic [2:0] ctx_reg_sel_out;
  logic mem_req_out, mem_we_out, reg_we_out, flag_we_out, sp_we_out, busy_out, done_out;
  logic flag_s_out, flag_z_out, flag_o_out, flag_c_out;
  logic [19:0] mem_addr_out;
  logic [7:0] mem_wdata_out;
  logic [15:0] reg_wdata_out, sp_out, g_reg, p, v;
  logic [3:0] g_flags;
  logic [19:0] e;
  logic [7:0] corr, val;
  logic wr, sx, zx;
  int fail_count = 0;
  int n_compared = 0;
  int n_reg, n_flag, n_sp, n;
  logic [2:0] sm [8] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h1, 3'h2, 3'h0};
  logic [15:0] ss [8] = '{16'h0003, 16'h0001, 16'h0002, 16'h1234, 16'h00ff, 16'hff01,
                          16'hab10, 16'h0080};
  logic [15:0] sd [8] = '{16'h0005, 16'h8000, 16'h0001, 16'h1234, 16'h007f, 16'h1200,
                          16'h0020, 16'h3300};
  logic [17:0] et [4] = '{{2'b10, 16'h8001}, {2'b01, 16'h0100}, {2'b00, 16'h0080},
                          {2'b00, 16'h5500}};
  logic [15:0] cta [2] = '{16'h0040, 16'h0041};
  logic [19:0] ctb [2] = '{20'h30000, 20'hf0010};
  logic [7:0] ctn [2] = '{8'h03, 8'h00};
  logic [7:0] csel [2] = '{8'ha1, 8'hff};
  logic [15:0] csp [2] = '{16'h0800, 16'h1000};

  // Register file stand-in: each index returns a value that names it.
  assign ctx_reg_val_in = {5'h15, ctx_reg_sel_out, 5'h0a, ctx_reg_sel_out};

  scse_core scse_core_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(start_in), .op_in(op_in),
    .word_in(word_in), .src_areg_in(src_areg_in), .dst_areg_in(dst_areg_in),
    .dst_mem_in(dst_mem_in), .src_in(src_in), .dst_in(dst_in), .imm_first_in(imm_first_in),
    .imm_second_in(imm_second_in), .dst_addr_in(dst_addr_in), .task_addr_in(task_addr_in),
    .table_addr_in(table_addr_in), .sp_in(sp_in), .flag_z_in(flag_z_in),
    .ctx_reg_val_in(ctx_reg_val_in), .ctx_reg_sel_out(ctx_reg_sel_out),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in),
    .reg_we_out(reg_we_out), .reg_wdata_out(reg_wdata_out), .flag_we_out(flag_we_out),
    .flag_s_out(flag_s_out), .flag_z_out(flag_z_out), .flag_o_out(flag_o_out),
    .flag_c_out(flag_c_out), .sp_we_out(sp_we_out), .sp_out(sp_out),
    .busy_out(busy_out), .done_out(done_out)
  );

  scse_mem_model mem_model_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in),
    .ack_out(mem_ack_in), .lat_in(lat)
  );

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (reg_we_out === 1'b1) begin
      n_reg++;
      g_reg = reg_wdata_out;
    end
    if (flag_we_out === 1'b1) begin
      n_flag++;
      g_flags = {flag_s_out, flag_z_out, flag_o_out, flag_c_out};
    end
    if (sp_we_out === 1'b1) begin
      n_sp++;
    end
  end

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input string nm, input logic [27:0] ev, input logic [27:0] gv);
    n_compared++;
    if (gv !== ev) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ev, gv);
    end
  endtask : check_val

  task automatic check_cnt(input string nm, input int ev, input int gv);
    n_compared++;
    if (gv != ev) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, ev, gv);
    end
  endtask : check_cnt

  // Returns {difference, sign, zero, overflow, carry}.
  function automatic logic [19:0] ref_sub(input logic w, input logic da,
                                          input logic [15:0] s, input logic [15:0] d);
    logic [16:0] r;
    logic [15:0] b;
    logic [8:0] r8;
    b = w ? s : {8'h00, s[7:0]};
    r = {1'b0, d} - {1'b0, b};
    r8 = {1'b0, d[7:0]} - {1'b0, b[7:0]};
    if (w || da) begin
      return {r[15:0], r[15], r[15:0] == 16'h0000, (d[15] ^ b[15]) & (r[15] ^ d[15]), ~r[16]};
    end
    return {8'h00, r8[7:0], r8[7], r8[7:0] == 8'h00, (d[7] ^ b[7]) & (r8[7] ^ d[7]), ~r8[8]};
  endfunction : ref_sub

  // Mode bits are {word, source areg, destination areg, memory destination, zero flag}.
  // The poke option offers a second request while busy, which must be ignored.
  task automatic launch(input scse_op_type op, input logic [4:0] m, input logic [15:0] s,
                        input logic [15:0] d, input logic [19:0] a, input bit poke);
    int k;
    @(posedge clk_in);
    n_reg = 0;
    n_flag = 0;
    n_sp = 0;
    g_reg = 16'hffff;
    mem_model_inst.wlog.delete();
    start_in <= 1'b1;
    op_in <= op;
    {word_in, src_areg_in, dst_areg_in, dst_mem_in, flag_z_in} <= m;
    src_in <= s;
    dst_in <= d;
    dst_addr_in <= a;
    @(posedge clk_in);
    start_in <= 1'b0;
    if (poke) begin
      repeat (2) @(posedge clk_in);
      start_in <= 1'b1;
      op_in <= SCSE_OP_SUB;
      @(posedge clk_in);
      start_in <= 1'b0;
    end
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
      if (k == 1) begin
        check_val("busy", 28'h0000001, {27'h0000000, busy_out});
      end
    end while (done_out !== 1'b1 && k < 400);
    // Let the write-back monitor finish with the done edge before counts are read.
    @(negedge clk_in);
    check_cnt("done seen", 1, int'(k < 400));
    check_val("idle", 28'h0000000, {27'h0000000, busy_out});
  endtask : launch

  initial begin
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      launch(SCSE_OP_SUB, {sm[i], 2'b00}, ss[i], sd[i], 20'h00000, 1'b0);
      e = ref_sub(sm[i][2], sm[i][0], ss[i], sd[i]);
      check_val("sub result", {12'h000, e[19:4]}, {12'h000, g_reg});
      check_val("sub flags", {24'h000000, e[3:0]}, {24'h000000, g_flags});
      check_cnt("sub writes", 2, n_reg + n_flag);
    end
    launch(SCSE_OP_SUB, 5'h12, 16'h0001, 16'h0100, 20'h00300, 1'b0);
    check_val("sub mem low", {20'h00300, 8'hff}, mem_model_inst.wlog[0]);
    check_val("sub mem high", {20'h00301, 8'h00}, mem_model_inst.wlog[1]);
    check_val("sub mem flags", 28'h0000001, {24'h000000, g_flags});
    check_cnt("sub mem reg writes", 0, n_reg);
    for (int i = 0; i < 4; i++) begin
      launch(SCSE_OP_EXT, {et[i][17:16], 3'h2}, et[i][15:0], 16'h0000,
             20'h12340 + 20'(i * 16), 1'b0);
      sx = et[i][17] | et[i][16] ? et[i][15] : et[i][7];
      zx = et[i][17] | et[i][16] ? et[i][15:0] == 16'h0000 : et[i][7:0] == 8'h00;
      check_val("ext low", {20'h12340 + 20'(i * 16), et[i][7:0]}, mem_model_inst.wlog[0]);
      if (et[i][17]) begin
        check_val("ext high", {20'h12341, et[i][15:8]}, mem_model_inst.wlog[1]);
      end
      check_cnt("ext writes", et[i][17] ? 2 : 1, mem_model_inst.wlog.size());
      check_val("ext flags", {26'h0000000, sx, zx}, {26'h0000000, g_flags[3:2]});
    end
    for (int o = 2; o < 5; o++) begin
      for (int c = 0; c < 4; c++) begin
        mem_model_inst.mem[20'h00200] = 8'h5a;
        launch(scse_op_type'(o), {3'h0, c[1], c[0]}, 16'h0000, 16'h0000, 20'h00200, 1'b0);
        wr = (o == 2) ? !c[0] : ((o == 3) ? c[0] : 1'b1);
        val = (o == 4 && !c[0]) ? 8'hc3 : 8'h3c;
        if (c[1]) begin
          check_val("cond mem", {20'h0, wr ? val : 8'h5a}, {20'h0, mem_model_inst.mem[20'h00200]});
        end else begin
          check_cnt("cond reg writes", int'(wr), n_reg);
          check_val("cond reg", wr ? {12'h000, 8'h00, val} : 28'h000ffff,
                    {12'h000, g_reg});
        end
        check_cnt("cond flag writes", 0, n_flag);
      end
    end
    for (int r = 0; r < 2; r++) begin
      corr = 8'(2 * $countones(csel[r]));
      mem_model_inst.mem[{4'h0, cta[r]}] = ctn[r];
      mem_model_inst.mem[ctb[r] + {11'h000, ctn[r], 1'b0}] = csel[r];
      mem_model_inst.mem[ctb[r] + {11'h000, ctn[r], 1'b0} + 20'h00001] = corr;
      @(posedge clk_in);
      task_addr_in <= cta[r];
      table_addr_in <= ctb[r];
      sp_in <= csp[r];
      lat <= (r == 0) ? 4'h0 : 4'h3;
      launch(SCSE_OP_CTX, 5'h00, 16'h0000, 16'h0000, 20'h00000, r == 0);
      p = csp[r];
      n = 0;
      for (int j = 0; j < 8; j++) begin
        if (csel[r][7 - j]) begin
          p = p - 16'h0002;
          v = {5'h15, 3'(j), 5'h0a, 3'(j)};
          check_val("ctx high", {4'h0, p + 16'h0001, v[15:8]}, mem_model_inst.wlog[n]);
          check_val("ctx low", {4'h0, p, v[7:0]}, mem_model_inst.wlog[n + 1]);
          n = n + 2;
        end
      end
      check_cnt("ctx writes", n, mem_model_inst.wlog.size());
      check_val("ctx sp", {12'h000, csp[r] - {8'h00, corr}}, {12'h000, sp_out});
      check_cnt("ctx sp writes", 1, n_sp);
      check_cnt("ctx reg writes", 0, n_reg);
    end
    print_verdict();
  end

  // The whole sequence needs well under 2000 cycles even with slow memory.
  initial begin
    #(40 * 20000);
    fail_count++;
    print_verdict();
  end
endmodule : tb
